// file: rtl/grn_notifier.sv
// Purpose: Engine-side sender of the gear-request-denied notification frames.
// Assumes: Byte streams to a serial bus controller on the same clock; tap pins asynchronous.
// Notes: Registers over APB, zero wait states.
// Behaviour
// - Distinct load headers differ only qualifier
// - Only this side originates load frames
// - Evaluate gear on each rising tap edge
// - Denied request sends load with qualifier one
// - Packet byte always sent as zero
// - Any field change sends new load
// - Answer current value request with load
// - Change trigger only in run mode
// - Report only confirms latest load received
// - Matching report halts pending retransmissions
// - Accept only even upper header nibble
// - Receive actions only in run mode
// - Period bits seven to five, zero
// - Duty bits four to three, zero
// - Criticality bits two to zero, zero
`timescale 1ns/100ps
`include "grn_map.svh"
module grn_notifier
  import grn_pkg::*;
#(
  parameter int RETRY_CYC = `GRN_RETRY_MS * 1000 * `GRN_CLK_MHZ
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Driver controls and operating state.
  input wire logic i_tap_up,
  input wire logic i_tap_down,
  input wire logic i_gear_allowed,
  input wire logic i_run_mode,
  // Transmit byte stream.
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  // Receive byte stream.
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  // Interrupt.
  output logic o_irq
);
  initial begin
    if (RETRY_CYC < 2) begin
      $error("RETRY_CYC must be at least 2");
    end
  end

  // Tap pin synchronisers and edge history.
  logic up_s1, up_s2, up_s3, dn_s1, dn_s2, dn_s3;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {up_s1, up_s2, up_s3} <= 3'h0;
      {dn_s1, dn_s2, dn_s3} <= 3'h0;
    end else begin
      {up_s1, up_s2, up_s3} <= {i_tap_up, up_s1, up_s2};
      {dn_s1, dn_s2, dn_s3} <= {i_tap_down, dn_s1, dn_s2};
    end
  end

  wire tap_evt = (up_s2 & ~up_s3) | (dn_s2 & ~dn_s3);
  wire deny_evt = tap_evt & ~i_gear_allowed;

  // APB decode.
  wire apb_acc = i_psel & i_penable;
  wire apb_wr = apb_acc & i_pwrite;
  wire sel_ctrl = (i_paddr == `GRN_ADDR_CTRL);
  wire sel_stat = (i_paddr == `GRN_ADDR_STATUS);
  wire sel_ist = (i_paddr == `GRN_ADDR_INT_STAT);
  wire sel_imsk = (i_paddr == `GRN_ADDR_INT_MASK);
  wire sel_rcnt = (i_paddr == `GRN_ADDR_RETRY_CNT);
  wire sel_any = sel_ctrl | sel_stat | sel_ist | sel_imsk | sel_rcnt;
  wire wr_ctrl = apb_wr & sel_ctrl;
  wire cancel = wr_ctrl & i_pwdata[`GRN_CTRL_CANCEL];
  wire resend = wr_ctrl & i_pwdata[`GRN_CTRL_RESEND];

  // Notification state, transmit state and retry bookkeeping.
  logic q;
  logic q_sent;
  logic send_req;
  logic await_ack;
  logic [31:0] retry_tmr;
  logic [15:0] retry_cnt;
  grn_tx_e tx_state;
  grn_idx_t tx_idx;

  // Receive capture.
  grn_idx_t rx_cnt;
  logic [7:0] rx_b0, rx_b1, rx_b3;

  // Qualifier update: a denial wins over a software cancel in the same cycle.
  wire next_q = deny_evt ? 1'b1 : (cancel ? 1'b0 : q);
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  wire rx_even = ~rx_b0[`GRN_RX_PRIO_LSB];
  wire rx_end = i_rx_valid & i_rx_last;
  wire rx_len_ok = (rx_cnt == (`GRN_HDR_LEN - 3'h1));
  wire rx_id = (rx_b1 == `GRN_RX_B1) & (rx_b3[6:0] == `GRN_ID_B3) & (i_rx_data == `GRN_ID_B4);
  wire rx_ok = rx_end & rx_len_ok & rx_id & rx_even;
  wire rx_act = rx_ok & i_run_mode;
  wire ack_evt = rx_act & (rx_b0[3:0] == `GRN_FEEDBACK_NIB) & (rx_b3[`GRN_Q_BIT] == q_sent);
  wire req_evt = rx_act & (rx_b0[3:0] == `GRN_CVREQ_NIB) & ~rx_b3[`GRN_Q_BIT];
  wire drop_evt = rx_end & rx_len_ok & rx_id & ~rx_even;

  // Receive byte counter and header capture.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_cnt <= 3'h0;
      rx_b0 <= 8'h00;
      rx_b1 <= 8'h00;
      rx_b3 <= 8'h00;
    end else if (i_rx_valid) begin
      if (rx_cnt == 3'h0) begin
        rx_b0 <= i_rx_data;
      end
      if (rx_cnt == 3'h1) begin
        rx_b1 <= i_rx_data;
      end
      if (rx_cnt == 3'h3) begin
        rx_b3 <= i_rx_data;
      end
      if (i_rx_last) begin
        rx_cnt <= 3'h0;
      end else if (rx_cnt != 3'h7) begin
        rx_cnt <= rx_cnt + 3'h1;
      end
    end
  end

  // Transmit handshake decode.
  wire tx_fire = o_tx_valid & i_tx_ready;
  wire tx_done = tx_fire & o_tx_last;
  wire retry_due = await_ack & (tx_state == GRN_TX_IDLE) &
                   (retry_tmr == 32'(RETRY_CYC - 1));
  wire chg_evt = (next_q != q) & i_run_mode;
  wire start = send_req & i_run_mode & (tx_state == GRN_TX_IDLE);

  // Pending send request: new triggers win over the clear taken at frame start.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      send_req <= 1'b0;
    end else if (chg_evt | (deny_evt & i_run_mode) | req_evt | resend | retry_due) begin
      send_req <= 1'b1;
    end else if (start) begin
      send_req <= 1'b0;
    end
  end

  // Frame sequencer.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state <= GRN_TX_IDLE;
      tx_idx <= 3'h0;
      q_sent <= 1'b0;
    end else begin
      unique case (tx_state)
        GRN_TX_IDLE: begin
          if (start) begin
            tx_state <= GRN_TX_SEND;
            tx_idx <= 3'h0;
            q_sent <= q;
          end
        end
        GRN_TX_SEND: begin
          if (tx_done) begin
            tx_state <= GRN_TX_IDLE;
          end else if (tx_fire) begin
            tx_idx <= tx_idx + 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      await_ack <= 1'b0;
      retry_tmr <= 32'h0;
      retry_cnt <= 16'h0;
    end else begin
      if (tx_done) begin
        await_ack <= 1'b1;
      end else if (ack_evt) begin
        await_ack <= 1'b0;
      end
      if (tx_done | retry_due | ~await_ack) begin
        retry_tmr <= 32'h0;
      end else if (tx_state == GRN_TX_IDLE) begin
        retry_tmr <= retry_tmr + 32'h1;
      end
      if (retry_due & (retry_cnt != 16'hFFFF)) begin
        retry_cnt <= retry_cnt + 16'h1;
      end else if (ack_evt & ~tx_done) begin
        retry_cnt <= 16'h0;
      end
    end
  end

  wire [7:0] packet_byte = {`GRN_PER_DC, `GRN_DUTY_DC, `GRN_CRIT_DC};
  wire [7:0] load_b3 = {q_sent, `GRN_ID_B3};
  // Byte selection for the load-command frame.
  wire [7:0] tx_byte = (tx_idx == 3'h0) ? `GRN_LOAD_B0 :
                       (tx_idx == 3'h1) ? `GRN_LOAD_B1 :
                       (tx_idx == 3'h2) ? `GRN_LOAD_B2 :
                       (tx_idx == 3'h3) ? load_b3 :
                       (tx_idx == 3'h4) ? `GRN_ID_B4 : packet_byte;

  // Transmit outputs.
  assign o_tx_valid = (tx_state == GRN_TX_SEND);
  assign o_tx_data = tx_byte;
  assign o_tx_last = o_tx_valid & (tx_idx == (`GRN_LOAD_LEN - 3'h1));

  // Interrupt status, set wins over write-one-to-clear.
  logic [`GRN_INT_W-1:0] int_stat;
  logic [`GRN_INT_W-1:0] int_mask;
  wire [`GRN_INT_W-1:0] int_set = {drop_evt, req_evt, ack_evt, deny_evt};
  wire [`GRN_INT_W-1:0] int_clr = (apb_wr & sel_ist) ? i_pwdata[`GRN_INT_W-1:0] :
                                  {`GRN_INT_W{1'b0}};
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_stat <= {`GRN_INT_W{1'b0}};
      int_mask <= `GRN_INT_MASK_RST;
    end else begin
      int_stat <= int_set | (int_stat & ~int_clr);
      if (apb_wr & sel_imsk) begin
        int_mask <= i_pwdata[`GRN_INT_W-1:0];
      end
    end
  end
  assign o_irq = |(int_stat & int_mask);

  // Status word and read data selection.
  wire [3:0] status = {i_run_mode, o_tx_valid, await_ack, q};
  wire [31:0] rd_mux = sel_stat ? {28'h0, status} :
                       sel_ist ? {28'h0, int_stat} :
                       sel_imsk ? {28'h0, int_mask} :
                       sel_rcnt ? {16'h0, retry_cnt} : 32'h0;

  // Read data register, loaded in the setup cycle.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0;
    end else if (i_psel & ~i_penable) begin
      o_prdata <= rd_mux;
    end
  end
  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc & ~sel_any;
endmodule

// file: rtl/grn_map.svh
// Purpose: Offsets, field positions, frame bytes and reset values of the notifier.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef GRN_MAP_SVH
`define GRN_MAP_SVH
// Register byte addresses.
`define GRN_ADDR_CTRL 8'h00
`define GRN_ADDR_STATUS 8'h04
`define GRN_ADDR_INT_STAT 8'h08
`define GRN_ADDR_INT_MASK 8'h0C
`define GRN_ADDR_RETRY_CNT 8'h10
// Control bits, write one to act.
`define GRN_CTRL_CANCEL 0
`define GRN_CTRL_RESEND 1
// Status bits.
`define GRN_ST_Q 0
`define GRN_ST_AWAIT 1
`define GRN_ST_BUSY 2
`define GRN_ST_RUN 3
// Interrupt bits.
`define GRN_INT_DENY 0
`define GRN_INT_ACK 1
`define GRN_INT_REQ 2
`define GRN_INT_DROP 3
`define GRN_INT_W 4
`define GRN_INT_MASK_RST 4'h0
// Load-command frame bytes.
`define GRN_LOAD_B0 8'h8A
`define GRN_LOAD_B1 8'hEA
`define GRN_LOAD_B2 8'h10
`define GRN_ID_B3 7'h22
`define GRN_ID_B4 8'hA4
`define GRN_Q_BIT 7
// Receive header matching.
`define GRN_RX_PRIO_LSB 4
`define GRN_FEEDBACK_NIB 4'hA
`define GRN_CVREQ_NIB 4'hB
`define GRN_RX_B1 8'hEB
// Packet byte fields, all held at the don't-care code.
`define GRN_PER_MSB 7
`define GRN_PER_LSB 5
`define GRN_DUTY_MSB 4
`define GRN_DUTY_LSB 3
`define GRN_CRIT_MSB 2
`define GRN_CRIT_LSB 0
`define GRN_PER_DC 3'h0
`define GRN_DUTY_DC 2'h0
`define GRN_CRIT_DC 3'h0
// Frame geometry and retry timing.
`define GRN_LOAD_LEN 3'h6
`define GRN_HDR_LEN 3'h5
`define GRN_RETRY_MS 100
`define GRN_CLK_MHZ 100
`endif

// file: rtl/grn_pkg.sv
// Purpose: Types shared by the notifier.
// Assumes: Nothing beyond the map header.
// Notes: Holds types only.
package grn_pkg;
  typedef enum logic [0:0] {GRN_TX_IDLE, GRN_TX_SEND} grn_tx_e;
  typedef logic [2:0] grn_idx_t;
endpackage

// file: tb/grn_notifier_sva.sv
// Purpose: Port checks of the notifier.
// Assumes: Zero-wait APB and six-byte load frames.
// Notes: Bound to the design from the bench top.
`timescale 1ns/100ps
module grn_notifier_chk (
  input wire logic i_core_clk, i_rst_b, i_psel, i_penable, i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr, i_run_mode, o_tx_valid, o_tx_last, i_tx_ready,
  input wire logic [7:0] o_tx_data,
  input wire logic o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic [2:0] bc;
  wire acc = i_psel && i_penable;
  // Counts the accepted bytes of the frame on offer.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) bc <= 3'h0;
    else if (o_tx_valid && i_tx_ready) bc <= o_tx_last ? 3'h0 : bc + 3'h1;
  end
  AST_HDR: assert property (o_tx_valid && bc < 3'h3 |-> o_tx_data ==
    (bc == 3'h0 ? 8'h8A : (bc == 3'h1 ? 8'hEA : 8'h10))) else $error("Header byte wrong");
  AST_ID: assert property (o_tx_valid && bc > 3'h2 && bc < 3'h5 |->
    (bc == 3'h3 ? o_tx_data[6:0] == 7'h22 : o_tx_data == 8'hA4)) else $error("Id byte wrong");
  AST_PACKET: assert property (o_tx_valid && (bc == 3'h5 || o_tx_last) |->
    o_tx_last && bc == 3'h5 && o_tx_data == 8'h00) else $error("Packet byte wrong");
  AST_HOLD: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data)) else $error("Byte dropped under stall");
  AST_GAP: assert property (o_tx_valid && i_tx_ready && o_tx_last |=> !o_tx_valid)
    else $error("No idle cycle after frame");
  AST_RUN: assert property ($rose(o_tx_valid) |-> $past(i_run_mode))
    else $error("Frame started outside run mode");
  AST_ERR: assert property (acc && i_paddr > 8'h10 |-> o_pslverr) else $error("No slave error");
  AST_CTRL: assert property (acc && !i_pwrite && i_paddr == 8'h00 |-> o_prdata == 32'h0)
    else $error("Control read not zero");
  COV_FRAME: cover property (o_tx_valid && i_tx_ready && o_tx_last);
  COV_STALL: cover property (o_tx_valid && !i_tx_ready);
  COV_IRQ: cover property ($rose(o_irq));
endmodule

// file: tb/grn_display_model.sv
// Purpose: Display-side node that answers load frames with feedback frames.
// Assumes: Same clock as the notifier.
// Notes: The bench can stall, mute and inject one frame.
`timescale 1ns/100ps
module grn_display_model (
  input wire logic i_core_clk, i_rst_b, i_stall, i_mute, i_go,
  input wire logic [7:0] i_b0, i_b3, i_tx_data,
  input wire logic i_tx_valid, i_tx_last,
  output logic o_tx_ready, o_rx_valid, o_rx_last,
  output logic [7:0] o_rx_data
);
  logic [39:0] frm;
  logic [2:0] left;
  logic q, ph, shown;
  wire take = i_tx_valid && o_tx_ready;
  // Stalling withholds ready every other cycle.
  assign o_tx_ready = !(i_stall && ph);
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {ph, q, shown, o_rx_valid, o_rx_last, left, o_rx_data, frm} <= '0;
    end else begin
      ph <= !ph;
      if (take && i_tx_data[6:0] == 7'h22) q <= i_tx_data[7];
      if (left != 3'h0) begin
        o_rx_valid <= 1'b1;
        o_rx_data <= frm[39:32];
        o_rx_last <= left == 3'h1;
        frm <= {frm[31:0], 8'h00};
        left <= left - 3'h1;
      end else begin
        o_rx_valid <= 1'b0;
        o_rx_last <= 1'b0;
        o_rx_data <= ~o_rx_data;
        if (take && i_tx_last && !i_mute) begin
          frm <= {16'hAAEB, 8'h10, q, 7'h22, 8'hA4};
          left <= 3'h5;
          shown <= q;
        end else if (i_go) begin
          frm <= {i_b0, 16'hEB10, i_b3, 8'hA4};
          left <= 3'h5;
        end
      end
    end
  end
endmodule

// file: tb/grn_notifier_tb_top.sv
// Purpose: Self-checking bench of the notifier.
// Assumes: Retry interval shortened to 50 cycles.
// Notes: Load frames are collected from the byte stream.
`timescale 1ns/100ps
module grn_notifier_tb_top;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, tu = 0, td = 0, allow = 1;
  logic run = 0, stall = 0, mute = 0, go = 0, se, pready, slverr, txv, txl, txr;
  logic rxv, rxl, irq;
  logic [7:0] addr = 8'h00, b0 = 8'h00, b3 = 8'h00, txd, rxd, txq[$];
  logic [31:0] wd = 32'h0, rd, prdata;
  int err_total = 0, total_checks = 0;
  initial forever #5 clk = ~clk;
  grn_notifier #(.RETRY_CYC(50)) u_grn_notifier (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr), .i_tap_up(tu),
    .i_tap_down(td), .i_gear_allowed(allow), .i_run_mode(run), .o_tx_valid(txv),
    .o_tx_data(txd), .o_tx_last(txl), .i_tx_ready(txr), .i_rx_valid(rxv),
    .i_rx_data(rxd), .i_rx_last(rxl), .o_irq(irq));
  grn_display_model u_grn_display_model (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_stall(stall), .i_mute(mute), .i_go(go), .i_b0(b0), .i_b3(b3), .i_tx_data(txd),
    .i_tx_valid(txv), .i_tx_last(txl), .o_tx_ready(txr), .o_rx_valid(rxv),
    .o_rx_last(rxl), .o_rx_data(rxd));
  // Collects every accepted transmit byte.
  always @(posedge clk) if (txv && txr) txq.push_back(txd);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer, setup then access until ready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwr, addr, wd} <= {1'b1, w, a, d};
    @(posedge clk) pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      if (++n > 20) begin err_total++; close_out(); end
      @(posedge clk);
    end
    rd = prdata;
    se = slverr;
    {psel, pen} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Waits for one load frame and compares its six bytes.
  task automatic frame(input logic q);
    int n;
    logic [47:0] e;
    e = {24'h8AEA10, q, 7'h22, 16'hA400};
    n = 0;
    while (txq.size() < 6) begin
      if (++n > 300) begin err_total++; close_out(); end
      @(posedge clk);
    end
    for (int i = 0; i < 6; i++) chk("tx byte", e[47-8*i -: 8], txq.pop_front());
  endtask
  task automatic quiet(input int c);
    repeat (c) @(posedge clk);
    chk("frame count", 0, txq.size());
  endtask
  task automatic tap(input logic up);
    if (up) tu <= 1'b1;
    else td <= 1'b1;
    repeat (4) @(posedge clk);
    {tu, td} <= 2'b00;
  endtask
  task automatic inject(input logic [7:0] h);
    {b0, b3, go} <= {h, 8'h22, 1'b1};
    @(posedge clk) go <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // Main sequence of tests.
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc("int mask", 8'h0C, 32'h0);
    rdc("status", 8'h04, 32'h0);
    apb(1'b1, 8'h0C, 32'hF);
    rdc("int mask", 8'h0C, 32'hF);
    rdc("unmapped", 8'h20, 32'h0);
    chk("pslverr", 1, se);
    $display("test registers done");
    {run, stall, allow} <= 3'b110;
    tap(1'b1);
    frame(1'b1);
    repeat (12) @(posedge clk);
    rdc("int stat", 8'h08, 32'h3);
    chk("irq", 1, irq);
    apb(1'b1, 8'h08, 32'hF);
    chk("irq", 0, irq);
    rdc("status", 8'h04, 32'h9);
    allow <= 1'b1;
    tap(1'b0);
    quiet(40);
    $display("test denial done");
    {mute, stall} <= 2'b10;
    apb(1'b1, 8'h00, 32'h1);
    frame(1'b0);
    frame(1'b0);
    rdc("retries", 8'h10, 32'h1);
    mute <= 1'b0;
    frame(1'b0);
    repeat (12) @(posedge clk);
    rdc("status", 8'h04, 32'h8);
    quiet(80);
    $display("test retry done");
    apb(1'b1, 8'h0C, 32'h8);
    apb(1'b1, 8'h08, 32'hF);
    inject(8'hCB);
    frame(1'b0);
    repeat (12) @(posedge clk);
    rdc("int stat", 8'h08, 32'h6);
    chk("irq", 0, irq);
    apb(1'b1, 8'h08, 32'hF);
    inject(8'hDB);
    quiet(30);
    rdc("int stat", 8'h08, 32'h8);
    chk("irq", 1, irq);
    $display("test request done");
    apb(1'b1, 8'h08, 32'hF);
    {run, allow} <= 2'b00;
    inject(8'hCB);
    tap(1'b1);
    quiet(60);
    // A denial is still evaluated outside run mode; only sending and receiving stop.
    rdc("int stat", 8'h08, 32'h1);
    $display("test run mode done");
    close_out();
  end
endmodule
bind grn_notifier grn_notifier_chk u_grn_notifier_chk (.*);
